// ### pkg/shc_pkg.sv
// Constants, register map and types for the serial handshake control block.
// Assumes a 250 MHz system clock and an AXI4-Lite register bus of 32 bits.
package shc_pkg;
  // ==========================================================================
  // Character codes
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_MODE2 = 8'h49;
  localparam logic [7:0] CH_ABORT = 8'h4A;
  localparam logic [7:0] CH_ON = 8'h59;
  localparam logic [7:0] CH_ON_ALT = 8'h28;
  localparam logic [7:0] CH_OFF = 8'h5A;
  localparam logic [7:0] CH_OFF_ALT = 8'h29;
  // ==========================================================================
  // Defaults and limits
  localparam logic [15:0] DEF_BLOCK = 16'h0050;
  localparam logic [15:0] DEF_BUF_SIZE = 16'h0400;
  localparam int TRIG_MAX = 10;
  localparam logic [6:0] CODE_MAX = 7'h7F;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BUFSIZE = 8'h04;
  localparam logic [7:0] REG_FREE = 8'h08;
  localparam logic [7:0] REG_XOFF_LVL = 8'h0C;
  localparam logic [7:0] REG_XON_LVL = 8'h10;
  localparam logic [7:0] REG_BLOCK = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_XOFF_CHR = 8'h1C;
  // CTRL fields
  localparam int CTRL_EAVES = 0;
  localparam int CTRL_STANDALONE = 1;
  localparam int CTRL_HARDWIRE = 2;
  // STATUS fields
  localparam int ST_ON = 0;
  localparam int ST_XONXOFF = 1;
  localparam int ST_ENQACK = 2;
  localparam int ST_STOPPED = 3;
  localparam int ST_DTR = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [2:0] {P_IDLE, P_ESC, P_CMD, P_PARAM} shc_pstate_t;
  typedef enum logic [1:0] {T_IDLE, T_ACK, T_STR, T_XOFF} shc_tstate_t;
endpackage : shc_pkg

// ### hw/shc_serial_handshake_control.sv
// Serial handshake control: flow control, abort and plotter on/off handling.
// Assumes a receive byte stream and a transmit byte port on the same clock,
// plus a break level from the terminal line arriving asynchronously.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module shc_serial_handshake_control
  import shc_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Receive stream
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  // Data to graphics buffer
  output logic DATA_VALID,
  output logic [7:0] DATA_BYTE,
  // Transmit stream
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Line signals
  input wire logic BREAK_IN,
  output logic DTR_OUT,
  output logic INPUT_EN,
  // Buffer fill from the buffer owner
  input wire logic [15:0] FREE_BYTES,
  // AXI4-Lite
  input wire logic [AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  typedef struct packed {
    shc_pstate_t ps;
    shc_tstate_t ts;
    logic [3:0] pidx;
    logic [15:0] acc;
    logic acc_any;
    logic [15:0] p1;
    logic p1_given;
    logic [7:0] p2;
    logic [TRIG_MAX-1:0][6:0] pend;
    logic [3:0] pcnt;
    logic [TRIG_MAX-1:0][6:0] trig;
    logic [3:0] tcnt;
    logic [3:0] tpos;
    logic xonxoff;
    logic enqack;
    logic [7:0] enq_chr;
    logic [15:0] block;
    logic [15:0] xoff_lvl;
    logic [15:0] xon_lvl;
    logic stopped;
    logic on;
    logic [7:0] ctrl;
    logic [15:0] bufsize;
    logic [7:0] xoff_chr;
    logic [2:0] brk_sync;
    logic brk_q;
    logic dvalid;
    logic [7:0] dbyte;
    logic txv;
    logic [7:0] txd;
    logic dtr;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } shc_state_t;

  shc_state_t s_reg, s_next;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  function automatic logic [15:0] acc_step(input logic [15:0] a, input logic [7:0] c);
    return 16'((a << 3) + (a << 1) + 16'(c - CH_ZERO));
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [15:0] half;
    logic [15:0] lvl;
    logic [7:0] c;
    logic brk_now;
    half = 16'h0000;
    lvl = 16'h0000;
    c = RX_DATA;
    brk_now = 1'b0;
    s_next = s_reg;
    s_next.dvalid = 1'b0;
    s_next.brk_sync = {s_reg.brk_sync[1:0], BREAK_IN};
    if (s_reg.brk_sync[2] == s_reg.brk_sync[1]) begin
      s_next.brk_q = s_reg.brk_sync[2];
    end
    brk_now = s_next.brk_q && !s_reg.brk_q;
    // Eavesdrop break behaves as plotter-off.
    if (brk_now && s_reg.ctrl[CTRL_EAVES] && !s_reg.ctrl[CTRL_STANDALONE]) begin
      s_next.on = 1'b0;
    end
    if (s_reg.ctrl[CTRL_STANDALONE]) begin
      s_next.on = 1'b1;
    end

    // Receive parser.
    if (RX_VALID) begin
      unique case (s_reg.ps)
        P_IDLE: begin
          if (c == CH_ESC) begin
            s_next.ps = P_ESC;
          end else if (c == CH_ENQ && s_reg.on) begin
            if (!s_reg.xonxoff && !s_reg.enqack) begin
              s_next.ts = T_ACK;
            end else if (s_reg.enqack && FREE_BYTES >= s_reg.block) begin
              s_next.ts = T_STR;
              s_next.tpos = 4'h0;
            end
          end else if (s_reg.on) begin
            s_next.dvalid = 1'b1;
            s_next.dbyte = c;
          end
        end
        P_ESC: begin
          s_next.ps = (c == CH_DOT) ? P_CMD : P_IDLE;
        end
        P_CMD: begin
          s_next.ps = P_IDLE;
          if (c == CH_ABORT) begin
            // Abort: cancel output and suppression, keep settings, reply nothing.
            s_next.ts = T_IDLE;
            s_next.txv = 1'b0;
            s_next.stopped = 1'b0;
          end else if (c == CH_ON || c == CH_ON_ALT) begin
            s_next.on = 1'b1;
          end else if ((c == CH_OFF || c == CH_OFF_ALT) && s_reg.on) begin
            s_next.on = s_reg.ctrl[CTRL_STANDALONE];
          end else if (c == CH_MODE2 && s_reg.on) begin
            s_next.ps = P_PARAM;
            s_next.pidx = 4'h0;
            s_next.acc = 16'h0000;
            s_next.acc_any = 1'b0;
            s_next.p1_given = 1'b0;
            s_next.p2 = 8'h00;
            s_next.pcnt = 4'h0;
          end
        end
        P_PARAM: begin
          if (is_digit(c)) begin
            s_next.acc = acc_step(s_reg.acc, c);
            s_next.acc_any = 1'b1;
          end else if (c == CH_SEMI || c == CH_COLON) begin
            if (s_reg.pidx == 4'h0) begin
              s_next.p1 = s_reg.acc;
              s_next.p1_given = s_reg.acc_any;
            end else if (s_reg.pidx == 4'h1) begin
              s_next.p2 = s_reg.acc[7:0];
            end else if (s_reg.acc_any && s_reg.pcnt < 4'(TRIG_MAX)
                         && s_reg.pcnt == s_reg.pidx - 4'h2 && s_reg.acc != 16'h0000) begin
              s_next.pend[s_reg.pcnt] = s_reg.acc[6:0] & CODE_MAX;
              s_next.pcnt = s_reg.pcnt + 4'h1;
            end
            s_next.acc = 16'h0000;
            s_next.acc_any = 1'b0;
            s_next.pidx = (s_reg.pidx == 4'hF) ? s_reg.pidx : s_reg.pidx + 4'h1;
            if (c == CH_COLON) begin
              s_next.ps = P_IDLE;
            end
          end else if (c == CH_ESC) begin
            // A fresh escape abandons the command; none of its parameters is committed.
            s_next.ps = P_ESC;
          end
        end
        default: s_next.ps = P_IDLE;
      endcase
    end

    // Commit the mode-2 command once its terminator has been parsed.
    if (s_reg.ps == P_PARAM && s_next.ps == P_IDLE) begin
      if (s_reg.ctrl[CTRL_HARDWIRE]) begin
        s_next.block = s_next.p1_given ? s_next.p1 : DEF_BLOCK;
      end else begin
        s_next.block = s_next.p1_given ? s_next.p1 : DEF_BLOCK;
        s_next.enq_chr = s_next.p2;
        s_next.enqack = (s_next.p2 != 8'h00);
        s_next.xonxoff = (s_next.p2 == 8'h00) && (s_next.pcnt != 4'h0);
        s_next.trig = s_next.pend;
        s_next.tcnt = s_next.pcnt;
        half = s_reg.bufsize >> 1;
        lvl = 16'(s_reg.bufsize - s_next.block);
        if (s_next.block > s_reg.bufsize || lvl < half) begin
          s_next.xoff_lvl = half;
          s_next.xon_lvl = 16'h0000;
        end else begin
          s_next.xoff_lvl = lvl;
          s_next.xon_lvl = (lvl > s_next.block) ? 16'(lvl - s_next.block) : 16'h0000;
        end
        s_next.stopped = 1'b0;
      end
    end

    // Xon-Xoff trigger decisions on the buffer fill level.
    if (s_reg.xonxoff && s_reg.ts == T_IDLE && s_next.ts == T_IDLE) begin
      if (!s_reg.stopped && 16'(s_reg.bufsize - FREE_BYTES) >= s_reg.xoff_lvl) begin
        s_next.stopped = 1'b1;
        s_next.ts = T_XOFF;
      end else if (s_reg.stopped && 16'(s_reg.bufsize - FREE_BYTES) <= s_reg.xon_lvl) begin
        s_next.stopped = 1'b0;
        s_next.ts = T_STR;
        s_next.tpos = 4'h0;
      end
    end
    s_next.dtr = (FREE_BYTES >= s_reg.block);

    // Transmitter: bare strings only, no initiator or terminator.
    if (s_reg.txv && TX_READY) begin
      s_next.txv = 1'b0;
    end
    if (!(s_reg.txv && !TX_READY) && s_next.ts == s_reg.ts) begin
      unique case (s_reg.ts)
        T_IDLE: ;
        T_ACK: begin
          s_next.txv = 1'b1;
          s_next.txd = CH_ACK;
          s_next.ts = T_IDLE;
        end
        T_STR: begin
          if (s_reg.tpos < s_reg.tcnt) begin
            s_next.txv = 1'b1;
            s_next.txd = {1'b0, s_reg.trig[s_reg.tpos]};
            s_next.tpos = s_reg.tpos + 4'h1;
          end else begin
            s_next.ts = T_IDLE;
          end
        end
        T_XOFF: begin
          s_next.txv = (s_reg.xoff_chr != 8'h00);
          s_next.txd = s_reg.xoff_chr;
          s_next.ts = T_IDLE;
        end
      endcase
    end

    // AXI4-Lite write.
    if (AWVALID && s_reg.awrdy) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = AWADDR;
    end
    if (WVALID && s_reg.wrdy) begin
      s_next.w_got = 1'b1;
      s_next.w_data = WDATA;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (s_reg.aw_addr)
        REG_CTRL: if (WSTRB[0]) s_next.ctrl = s_reg.w_data[7:0];
        REG_BUFSIZE: begin
          if (WSTRB[0]) s_next.bufsize[7:0] = s_reg.w_data[7:0];
          if (WSTRB[1]) s_next.bufsize[15:8] = s_reg.w_data[15:8];
        end
        REG_XOFF_CHR: if (WSTRB[0]) s_next.xoff_chr = s_reg.w_data[7:0];
        REG_FREE, REG_XOFF_LVL, REG_XON_LVL, REG_BLOCK, REG_STATUS: ;
        default: s_next.bresp = RESP_DECERR;
      endcase
    end
    if (s_reg.bvalid && BREADY) begin
      s_next.bvalid = 1'b0;
    end
    // Each channel is ready only while its slot is empty and no response waits.
    s_next.awrdy = !s_next.aw_got && !s_next.bvalid;
    s_next.wrdy = !s_next.w_got && !s_next.bvalid;

    // AXI4-Lite read.
    if (ARVALID && s_reg.arrdy) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      unique case (ARADDR)
        REG_CTRL: s_next.rdata = {24'h000000, s_reg.ctrl};
        REG_BUFSIZE: s_next.rdata = {16'h0000, s_reg.bufsize};
        REG_FREE: s_next.rdata = {16'h0000, FREE_BYTES};
        REG_XOFF_LVL: s_next.rdata = {16'h0000, s_reg.xoff_lvl};
        REG_XON_LVL: s_next.rdata = {16'h0000, s_reg.xon_lvl};
        REG_BLOCK: s_next.rdata = {16'h0000, s_reg.block};
        REG_STATUS: begin
          s_next.rdata[ST_ON] = s_reg.on;
          s_next.rdata[ST_XONXOFF] = s_reg.xonxoff;
          s_next.rdata[ST_ENQACK] = s_reg.enqack;
          s_next.rdata[ST_STOPPED] = s_reg.stopped;
          s_next.rdata[ST_DTR] = s_reg.dtr;
        end
        REG_XOFF_CHR: s_next.rdata = {24'h000000, s_reg.xoff_chr};
        default: s_next.rresp = RESP_DECERR;
      endcase
    end
    if (s_reg.rvalid && RREADY) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arrdy = !s_next.rvalid;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.ps <= P_IDLE;
      s_reg.ts <= T_IDLE;
      s_reg.on <= 1'b1;
      s_reg.block <= DEF_BLOCK;
      s_reg.bufsize <= DEF_BUF_SIZE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign DATA_VALID = s_reg.dvalid;
  assign DATA_BYTE = s_reg.dbyte;
  assign TX_VALID = s_reg.txv;
  assign TX_DATA = s_reg.txd;
  assign DTR_OUT = s_reg.dtr;
  assign INPUT_EN = s_reg.on;
  assign AWREADY = s_reg.awrdy;
  assign WREADY = s_reg.wrdy;
  assign BVALID = s_reg.bvalid;
  assign BRESP = s_reg.bresp;
  assign ARREADY = s_reg.arrdy;
  assign RVALID = s_reg.rvalid;
  assign RDATA = s_reg.rdata;
  assign RRESP = s_reg.rresp;

endmodule // shc_serial_handshake_control
`default_nettype wire

// ### verif/shc_assertions.sv
// Assertion checker bound to the serial handshake control top module.
// Assumes one clock domain with an active high asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module shc_assertions
  import shc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Link side
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic DATA_VALID,
  input wire logic [7:0] DATA_BYTE,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic INPUT_EN,
  // Register bus
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic BVALID,
  input wire logic BREADY
);
  // =====
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_ack_enq: assert property (
    RX_VALID && RX_DATA == CH_ENQ && INPUT_EN && !TX_VALID
    |-> ##[1:3] TX_VALID && TX_DATA == CH_ACK) else $error("no ACK after ENQ");
  a_abort_drop: assert property (
    RX_VALID && RX_DATA == CH_ESC ##1 RX_VALID && RX_DATA == CH_DOT
    ##1 RX_VALID && RX_DATA == CH_ABORT |-> ##[1:2] !TX_VALID) else $error("output kept");
  a_abort_quiet: assert property (
    RX_VALID && RX_DATA == CH_ESC ##1 RX_VALID && RX_DATA == CH_DOT
    ##1 RX_VALID && RX_DATA == CH_ABORT && !TX_VALID |=> !TX_VALID [*4])
    else $error("reply to abort");
  a_off_nodata: assert property (
    !$past(INPUT_EN) && !INPUT_EN |-> !DATA_VALID) else $error("data while off");
  a_esc_kept: assert property (
    RX_VALID && RX_DATA == CH_ESC |=> !(DATA_VALID && DATA_BYTE == CH_ESC))
    else $error("command byte forwarded");
  a_tx_stable: assert property (
    TX_VALID && !TX_READY |=> !TX_VALID || $stable(TX_DATA)) else $error("tx byte moved");
  a_b_stands: assert property (BVALID && !BREADY |=> BVALID) else $error("bvalid dropped");
  a_r_stands: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data dropped");
  a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("late read");
endmodule // shc_assertions
bind shc_serial_handshake_control shc_assertions u_shc_chk (
  .MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
  .DATA_VALID(DATA_VALID), .DATA_BYTE(DATA_BYTE), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_READY(TX_READY), .INPUT_EN(INPUT_EN), .ARVALID(ARVALID),
  .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .BVALID(BVALID), .BREADY(BREADY));
`default_nettype wire

// ### verif/shc_host_model.sv
// Host model: sends command strings on the receive stream and paces output.
// Assumes the bench calls send from its main process, one call at a time.
`timescale 1ns/100ps
`default_nettype none
module shc_host_model (
  // Clock and pacing
  input wire logic MCLK,
  input wire logic stall,
  // Link to the block
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic TX_READY
);
  // =====
  // Behaviour
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    TX_READY = 1'b0;
  end
  // Output is taken at a random pace, and not at all while stalled.
  always @(posedge MCLK) TX_READY <= !stall && $urandom_range(2) != 0;
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge MCLK);
      RX_VALID <= 1'b1;
      RX_DATA <= s[i];
    end
    @(posedge MCLK);
    RX_VALID <= 1'b0;
    // The released line shows the inverse of the last byte.
    RX_DATA <= ~RX_DATA;
  endtask
endmodule // shc_host_model
`default_nettype wire

// ### verif/shc_serial_handshake_control_tb.sv
// Self-checking bench for the serial handshake control block.
// Assumes the host model on the link and AXI4-Lite access to the registers.
`timescale 1ns/100ps
`default_nettype none
module shc_serial_handshake_control_tb;
  import shc_pkg::*;
  // =====
  // Signals
  logic MCLK, RST, stall, BREAK_IN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic RX_VALID, TX_READY, DATA_VALID, TX_VALID, DTR_OUT, INPUT_EN;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0] RX_DATA, DATA_BYTE, TX_DATA, AWADDR, ARADDR;
  logic [1:0] BRESP, RRESP;
  logic [15:0] FREE_BYTES;
  logic [31:0] WDATA, RDATA;
  int err_total, n_tests, cyc, t, xoff, xon;
  int exp_tx[$], exp_data[$];
  shc_serial_handshake_control #(.AW(8)) uut (
    .MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .DATA_VALID(DATA_VALID), .DATA_BYTE(DATA_BYTE), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .BREAK_IN(BREAK_IN), .DTR_OUT(DTR_OUT),
    .INPUT_EN(INPUT_EN), .FREE_BYTES(FREE_BYTES), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  shc_host_model host (.MCLK(MCLK), .stall(stall), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .TX_READY(TX_READY));
  always #2 MCLK = ~MCLK;
  // =====
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    {AWVALID, WVALID} <= 2'b11;
    fork
      begin
        do @(posedge MCLK); while (!AWREADY);
        AWVALID <= 1'b0;
      end
      begin
        do @(posedge MCLK); while (!WREADY);
        WVALID <= 1'b0;
      end
    join
    @(posedge MCLK);
    BREADY <= 1'b1;
    do @(posedge MCLK); while (!BVALID);
    BREADY <= 1'b0;
    chk(BRESP, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    do @(posedge MCLK); while (!RVALID);
    RREADY <= 1'b0;
    chk(RDATA & m, d);
    chk(RRESP, r);
  endtask
  task automatic w_en(input logic v);
    repeat (50) if (INPUT_EN !== v) @(posedge MCLK);
    chk(INPUT_EN, v);
  endtask
  task automatic w_tx();
    repeat (300) if (exp_tx.size() != 0) @(posedge MCLK);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // =====
  // Reference model comparisons and timeout
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
    if (!RST && TX_VALID && TX_READY) chk(TX_DATA, exp_tx.size() ? exp_tx.pop_front() : -1);
    if (!RST && DATA_VALID && DATA_BYTE !== CH_ENQ)
      chk(DATA_BYTE, exp_data.size() ? exp_data.pop_front() : -1);
  end
  // =====
  // Scenarios
  initial begin
    void'($urandom(16655));
    {MCLK, stall, BREAK_IN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA} = '0;
    FREE_BYTES = 16'h0400;
    RST = 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    rd(REG_BUFSIZE, 32'h0400, 32'hFFFF, RESP_OKAY);
    rd(8'h40, 32'h0, 32'h0, RESP_DECERR);
    wr(8'h44, 32'h0, RESP_DECERR);
    exp_tx.push_back(CH_ACK);
    exp_data = '{8'h41, 8'h42};
    host.send("A\005B");
    host.send("\033.I:");
    rd(REG_STATUS, 32'h1, 32'h7, RESP_OKAY);
    rd(REG_BLOCK, 32'h50, 32'hFFFF, RESP_OKAY);
    wr(REG_CTRL, 32'h4, RESP_OKAY);
    host.send("\033.I10:");
    rd(REG_BLOCK, 32'h0A, 32'hFFFF, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      t = $urandom_range(20);
      FREE_BYTES <= 16'(t);
      repeat (3) @(posedge MCLK);
      chk(DTR_OUT, t >= 10);
    end
    FREE_BYTES <= 16'h0400;
    stall <= 1'b1;
    host.send("\005");
    repeat (4) @(posedge MCLK);
    chk(TX_VALID, 1'b1);
    host.send("\033.J");
    repeat (4) @(posedge MCLK);
    chk(TX_VALID, 1'b0);
    stall <= 1'b0;
    host.send("\033.I12\033.J");
    rd(REG_BLOCK, 32'h0A, 32'hFFFF, RESP_OKAY);
    chk(INPUT_EN, 1'b1);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(REG_XOFF_CHR, 32'h13, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      t = i == 0 ? 81 : i == 1 ? 600 : 1 + $urandom_range(998);
      xoff = 1024 - t;
      xon = xoff - t;
      if (xoff < 512) begin
        xoff = 512;
        xon = 0;
      end
      FREE_BYTES <= 16'h0400;
      host.send(i == 0 ? $sformatf("\033.I%0d;0;17;0;18:", t) :
                $sformatf("\033.I%0d;;17;0;18:", t));
      rd(REG_XOFF_LVL, xoff, 32'hFFFF, RESP_OKAY);
      rd(REG_XON_LVL, xon, 32'hFFFF, RESP_OKAY);
      rd(REG_STATUS, 32'h3, 32'h7, RESP_OKAY);
      exp_tx.push_back(8'h13);
      FREE_BYTES <= 16'(1024 - xoff);
      w_tx();
      exp_tx.push_back(8'h11);
      FREE_BYTES <= 16'(1024 - xon);
      w_tx();
    end
    host.send("\033.I81;5;6:");
    rd(REG_STATUS, 32'h5, 32'h7, RESP_OKAY);
    exp_tx.push_back(8'h06);
    host.send("\005");
    w_tx();
    host.send("\033.I81;0:");
    rd(REG_STATUS, 32'h1, 32'h7, RESP_OKAY);
    host.send("\033.Z");
    w_en(1'b0);
    host.send("A\033.)");
    repeat (5) @(posedge MCLK);
    chk(INPUT_EN, 1'b0);
    exp_data = '{8'h42, 8'h43};
    host.send("\033.(B");
    w_en(1'b1);
    host.send("\033.YC");
    host.send("\033.)");
    w_en(1'b0);
    host.send("\033.Y");
    w_en(1'b1);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    BREAK_IN <= 1'b1;
    w_en(1'b0);
    BREAK_IN <= 1'b0;
    host.send("\033.Y");
    w_en(1'b1);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    host.send("\033.Z");
    BREAK_IN <= 1'b1;
    repeat (10) @(posedge MCLK);
    chk(INPUT_EN, 1'b1);
    w_tx();
    chk(exp_tx.size(), 0);
    chk(exp_data.size(), 0);
    summarize();
  end
endmodule // shc_serial_handshake_control_tb
`default_nettype wire
